// ---- hdl/ddr_port_map.svh ----
// constants of the double-rate port: widths, lanes, pipeline depths
`ifndef DDR_PORT_MAP_SVH
`define DDR_PORT_MAP_SVH
// Contract
// - read select low at a true-clock edge starts a read; high starts none
// - write select low at a true-clock edge starts a write; high starts none
// - cycles count from the true clock; half cycles mean the next complement edge
// - wide mode: first beat stores each nine-bit lane whose enable is low
// - second beat and its lane enables are captured at the complement edge
// - all lane enables high on a beat aborts that beat; data ignored
// - narrow mode: enable 0 gates bits 0 to 8, enable 1 bits 9 to 17
// - second beat uses the first address plus one
// - read and write sequencers run independently and concurrently
// - read data beat one at t+1.5, beat two at t+2.0; the port gives beat one at t+2.5 and beat two at t+3.0
`define LANE_BITS 9
`define LANE_COUNT 4
`define WORD_BITS 36
`define NARROW_BITS 18
`define ADDR_BITS 8
`define DEPTH 256
`define LANES_ALL_OFF 4'hF
`define NARROW_LANE_MASK 4'hC
`define WORD_ZERO 36'h0_0000_0000
`define ADDR_ZERO 8'h00
`define ADDR_ONE 8'h01
`define READ_STAGES 4
`endif

// ---- hdl/ddr_port_pkg.sv ----
// types shared by the double-rate port design
package ddr_port_pkg;
    // write sequencer position within a two-beat burst
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_ADDR,
        WR_SECOND
    } wr_state_t;
endpackage

// ---- hdl/lane_ram.sv ----
// dual-port storage with per-lane write enables and registered read data
`timescale 1ns/1ps
`include "ddr_port_map.svh"
module lane_ram
(
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [`ADDR_BITS-1:0] wr_addr,
    input wire logic [`LANE_COUNT-1:0] wr_lane,
    input wire logic [`WORD_BITS-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [`ADDR_BITS-1:0] rd_addr,
    output logic [`WORD_BITS-1:0] rd_data
);
    // one storage column per lane, so each column has a single writing process
    genvar g;
    generate
        for (g = 0; g < `LANE_COUNT; g = g + 1)
        begin : g_lane
            logic [`LANE_BITS-1:0] col [0:`DEPTH-1];
            logic [`LANE_BITS-1:0] q_r;
            // lane written only when its enable is set
            always_ff @(posedge clk)
            begin
                if (wr_en && wr_lane[g])
                begin
                    col[wr_addr] <= wr_data[g*`LANE_BITS +: `LANE_BITS];
                end
            end
            // registered read of this lane
            always_ff @(posedge clk)
            begin
                if (rd_en)
                begin
                    q_r <= col[rd_addr];
                end
            end
            assign rd_data[g*`LANE_BITS +: `LANE_BITS] = q_r;
        end
    endgenerate
endmodule

// ---- hdl/ddr_port.sv ----
// command and byte-lane write capture of a two-beat double-rate port
`timescale 1ns/1ps
`include "ddr_port_map.svh"
module ddr_port
    import ddr_port_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // commands
    input wire logic RD_SEL_N,
    input wire logic WR_SEL_N,
    input wire logic [`ADDR_BITS-1:0] ADDR,
    input wire logic X18_MODE,
    // write data and lane enables
    input wire logic [`WORD_BITS-1:0] DATA_IN,
    input wire logic LANE0_WRITE_ENABLE_N,
    input wire logic LANE1_WRITE_ENABLE_N,
    input wire logic LANE2_WRITE_ENABLE_N,
    input wire logic LANE3_WRITE_ENABLE_N,
    // read data and status
    output logic [`WORD_BITS-1:0] DATA_OUT,
    output logic DATA_OUT_VALID,
    output logic K_TRUE,
    output logic WR_READY
);
    localparam int SW = 3 + `ADDR_BITS + `WORD_BITS + `LANE_COUNT;
    localparam int EW = `ADDR_BITS + `WORD_BITS + `LANE_COUNT;

    // two-flop synchronisers on every pin
    logic [SW-1:0] pin_raw, sy1_r, sy2_r;
    assign pin_raw = {X18_MODE, RD_SEL_N, WR_SEL_N, ADDR, DATA_IN, LANE3_WRITE_ENABLE_N,
                      LANE2_WRITE_ENABLE_N, LANE1_WRITE_ENABLE_N, LANE0_WRITE_ENABLE_N};
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sy1_r <= {SW{1'b1}};
            sy2_r <= {SW{1'b1}};
        end
        else
        begin
            sy1_r <= pin_raw;
            sy2_r <= sy1_r;
        end
    end

    logic narrow, rd_n, wr_n;
    logic [`ADDR_BITS-1:0] addr_s;
    logic [`WORD_BITS-1:0] data_s;
    logic [`LANE_COUNT-1:0] lane_n;
    logic [`LANE_COUNT-1:0] lane_on;
    assign {narrow, rd_n, wr_n, addr_s, data_s, lane_n} = sy2_r;
    // narrow mode has only lanes 0 and 1
    assign lane_on = ~(narrow ? (lane_n | `NARROW_LANE_MASK) : lane_n);

    // true / complement edge phase: each CLK edge is one half cycle
    logic ktrue_r, ktrue_nxt;
    always_comb
    begin
        ktrue_nxt = ~ktrue_r;
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ktrue_r <= 1'b1;
        end
        else
        begin
            ktrue_r <= ktrue_nxt;
        end
    end

    // two-entry write buffer
    logic [EW-1:0] fb_r [0:1];
    logic [EW-1:0] fb_nxt [0:1];
    logic [1:0] fcnt_r, fcnt_nxt;
    logic push, pop, in_ready, out_ready;
    logic [EW-1:0] push_entry;
    assign in_ready = (fcnt_r != 2'h2);

    // write sequencer
    wr_state_t ws_r, ws_nxt;
    logic [`WORD_BITS-1:0] d0_r, d0_nxt, d1_r, d1_nxt;
    logic [`LANE_COUNT-1:0] l0_r, l0_nxt, l1_r, l1_nxt;
    logic [`ADDR_BITS-1:0] wa_r, wa_nxt;
    always_comb
    begin
        ws_nxt = ws_r;
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        l0_nxt = l0_r;
        l1_nxt = l1_r;
        wa_nxt = wa_r;
        push = 1'b0;
        push_entry = {wa_r, d0_r, l0_r};
        case (ws_r)
            WR_IDLE:
            begin
                // first beat taken with the command at the true edge
                if (ktrue_r && !wr_n)
                begin
                    d0_nxt = data_s;
                    l0_nxt = lane_on;
                    ws_nxt = WR_ADDR;
                end
            end
            WR_ADDR:
            begin
                // complement edge: address, second beat, lanes resampled
                d1_nxt = data_s;
                l1_nxt = lane_on;
                wa_nxt = addr_s + `ADDR_ONE;
                push_entry = {addr_s, d0_r, l0_r};
                push = (l0_r != 4'h0);
                ws_nxt = WR_SECOND;
            end
            WR_SECOND:
            begin
                push_entry = {wa_r, d1_r, l1_r};
                push = (l1_r != 4'h0);
                ws_nxt = WR_IDLE;
                // a new write may open on this same true edge
                if (!wr_n)
                begin
                    d0_nxt = data_s;
                    l0_nxt = lane_on;
                    ws_nxt = WR_ADDR;
                end
            end
            default:
            begin
                ws_nxt = WR_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ws_r <= WR_IDLE;
            d0_r <= `WORD_ZERO;
            d1_r <= `WORD_ZERO;
            l0_r <= 4'h0;
            l1_r <= 4'h0;
            wa_r <= `ADDR_ZERO;
        end
        else
        begin
            ws_r <= ws_nxt;
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
            l0_r <= l0_nxt;
            l1_r <= l1_nxt;
            wa_r <= wa_nxt;
        end
    end

    // read sequencer: stage shift plus burst addresses
    logic [`READ_STAGES:1] rv_r, rv_nxt;
    logic [`ADDR_BITS-1:0] ra_r, ra_nxt, rb_r, rb_nxt;
    logic [`WORD_BITS-1:0] hold_r, hold_nxt, q_r, q_nxt, ram_q;
    logic qv_r, qv_nxt;
    logic ram_rd_en;
    logic [`ADDR_BITS-1:0] ram_rd_addr;
    assign ram_rd_en = rv_r[1] | rv_r[2];
    assign ram_rd_addr = rv_r[1] ? ra_r : rb_r;
    always_comb
    begin
        rv_nxt = {rv_r[`READ_STAGES-1:1], ktrue_r & ~rd_n};
        ra_nxt = (ktrue_r && !rd_n) ? addr_s : ra_r;
        rb_nxt = rv_r[1] ? ra_r + `ADDR_ONE : rb_r;
        hold_nxt = (rv_r[2] | rv_r[3]) ? ram_q : hold_r;
        q_nxt = (rv_r[3] | rv_r[4]) ? hold_r : q_r;
        qv_nxt = rv_r[3] | rv_r[4];
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rv_r <= 4'h0;
            ra_r <= `ADDR_ZERO;
            rb_r <= `ADDR_ZERO;
            hold_r <= `WORD_ZERO;
            q_r <= `WORD_ZERO;
            qv_r <= 1'b0;
        end
        else
        begin
            rv_r <= rv_nxt;
            ra_r <= ra_nxt;
            rb_r <= rb_nxt;
            hold_r <= hold_nxt;
            q_r <= q_nxt;
            qv_r <= qv_nxt;
        end
    end

    // buffer drains unless the read port touches the same word this cycle
    logic [`ADDR_BITS-1:0] head_addr;
    logic [`WORD_BITS-1:0] head_data;
    logic [`LANE_COUNT-1:0] head_lane;
    assign {head_addr, head_data, head_lane} = fb_r[0];
    assign out_ready = !(ram_rd_en && ram_rd_addr == head_addr);
    assign pop = (fcnt_r != 2'h0) && out_ready;

    // buffer next state
    always_comb
    begin
        logic do_push;
        do_push = push && (in_ready || pop);
        fb_nxt[0] = fb_r[0];
        fb_nxt[1] = fb_r[1];
        fcnt_nxt = fcnt_r;
        if (pop)
        begin
            fb_nxt[0] = fb_r[1];
        end
        if (do_push)
        begin
            if (fcnt_r == 2'h0 || (fcnt_r == 2'h1 && pop))
            begin
                fb_nxt[0] = push_entry;
            end
            else
            begin
                fb_nxt[1] = push_entry;
            end
        end
        fcnt_nxt = fcnt_r + {1'b0, do_push} - {1'b0, pop};
    end
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            fb_r[0] <= {EW{1'b0}};
            fb_r[1] <= {EW{1'b0}};
            fcnt_r <= 2'h0;
        end
        else
        begin
            fb_r[0] <= fb_nxt[0];
            fb_r[1] <= fb_nxt[1];
            fcnt_r <= fcnt_nxt;
        end
    end

    // storage
    lane_ram u_ram
    (
        .clk(CLK),
        .wr_en(pop),
        .wr_addr(head_addr),
        .wr_lane(head_lane),
        .wr_data(head_data),
        .rd_en(ram_rd_en),
        .rd_addr(ram_rd_addr),
        .rd_data(ram_q)
    );

    // registered outputs
    logic wrdy_r;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wrdy_r <= 1'b1;
        end
        else
        begin
            wrdy_r <= (fcnt_nxt == 2'h0);
        end
    end
    assign DATA_OUT = q_r;
    assign DATA_OUT_VALID = qv_r;
    assign K_TRUE = ktrue_r;
    assign WR_READY = wrdy_r;
endmodule

// ---- testbench/ddr_port_monitor.sv ----
// checker of read latency, clock phase and write buffer status at the port pins
`timescale 1ns/1ps
module ddr_port_monitor
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // commands
    input wire logic RD_SEL_N,
    input wire logic WR_SEL_N,
    input wire logic LANE0_WRITE_ENABLE_N,
    input wire logic LANE1_WRITE_ENABLE_N,
    // status and data
    input wire logic [35:0] DATA_OUT,
    input wire logic DATA_OUT_VALID,
    input wire logic K_TRUE,
    input wire logic WR_READY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic rd_take;
    // read select seen at a true edge
    assign rd_take = !RD_SEL_N && K_TRUE;
    sequence rd_cmd;
        rd_take;
    endsequence
    // write with lane 0 or lane 1 enable low while the buffer is empty
    sequence wr_cmd;
        !WR_SEL_N && K_TRUE && WR_READY && !(LANE0_WRITE_ENABLE_N && LANE1_WRITE_ENABLE_N);
    endsequence
    a_read_beat_lat: assert property (rd_cmd |-> ##6 DATA_OUT_VALID [*2])
        else $error("read beats late or missing");
    a_read_has_cause: assert property ($rose(DATA_OUT_VALID) |-> $past(rd_take, 6))
        else $error("read data without read command");
    a_valid_from_read: assert property (DATA_OUT_VALID |-> $past(rd_take, 6) || $past(rd_take, 7))
        else $error("valid outside read beats");
    a_valid_two_beats: assert property ($fell(DATA_OUT_VALID) |-> $past(DATA_OUT_VALID, 2))
        else $error("read burst shorter than two beats");
    a_phase_alternates: assert property (1'b1 |=> K_TRUE != $past(K_TRUE))
        else $error("phase flag did not alternate");
    a_out_idle_hold: assert property (!DATA_OUT_VALID |-> $stable(DATA_OUT))
        else $error("read data moved while not valid");
    a_write_goes_busy: assert property (wr_cmd |-> ##[2:6] !WR_READY)
        else $error("write did not enter buffer");
    a_write_drains: assert property ($fell(WR_READY) |-> ##[1:40] WR_READY)
        else $error("write buffer never drained");
endmodule
bind ddr_port ddr_port_monitor i_mon (.CLK(CLK), .NRST(NRST), .RD_SEL_N(RD_SEL_N),
    .WR_SEL_N(WR_SEL_N), .LANE0_WRITE_ENABLE_N(LANE0_WRITE_ENABLE_N),
    .LANE1_WRITE_ENABLE_N(LANE1_WRITE_ENABLE_N), .DATA_OUT(DATA_OUT),
    .DATA_OUT_VALID(DATA_OUT_VALID), .K_TRUE(K_TRUE), .WR_READY(WR_READY));

// ---- testbench/ctrl_model.sv ----
// controller model: commands at true edges, second beat at complement edges; odd set swaps the two
`timescale 1ns/1ps
module ctrl_model
(
    // clock and phase
    input wire logic clk,
    input wire logic k_true,
    // pins toward the port
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic [7:0] addr,
    output logic [35:0] data,
    output logic [3:0] lane_n
);
    // idle pins from time zero
    initial
    begin
        rd_sel_n = 1'b1;
        wr_sel_n = 1'b1;
        addr = 8'h00;
        data = 36'h0_0000_0000;
        lane_n = 4'hF;
    end
    // odd set places the command on a complement edge instead
    task automatic issue(input logic r, input logic [7:0] ra, input logic w,
        input logic [7:0] wa, input logic [35:0] d0, input logic [3:0] l0,
        input logic [35:0] d1, input logic [3:0] l1, input logic odd);
        @(posedge clk);
        #1;
        while (k_true === odd)
        begin
            @(posedge clk);
            #1;
        end
        rd_sel_n = !r;
        wr_sel_n = !w;
        addr = ra;
        data = d0;
        lane_n = l0;
        @(posedge clk);
        #1;
        rd_sel_n = 1'b1;
        wr_sel_n = 1'b1;
        addr = wa;
        data = d1;
        lane_n = l1;
        @(posedge clk);
        #1;
        // released pins flip so stale values never pass for data
        addr = ~addr;
        data = ~data;
        lane_n = ~lane_n;
    endtask
endmodule

// ---- testbench/ddr_sram_port_byte_write_tb_top.sv ----
// testbench: lane writes, aborts, narrow mode, concurrency and read latency
`timescale 1ns/1ps
module ddr_sram_port_byte_write_tb_top;
    logic CLK, NRST, X18_MODE, rs, ws, valid, kt, wr_ready;
    logic [7:0] addr;
    logic [35:0] din, dout;
    logic [3:0] ln;
    logic [35:0] mem [256];
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    ddr_port i_dut (.CLK(CLK), .NRST(NRST), .RD_SEL_N(rs), .WR_SEL_N(ws), .ADDR(addr),
        .X18_MODE(X18_MODE), .DATA_IN(din), .LANE0_WRITE_ENABLE_N(ln[0]),
        .LANE1_WRITE_ENABLE_N(ln[1]), .LANE2_WRITE_ENABLE_N(ln[2]),
        .LANE3_WRITE_ENABLE_N(ln[3]), .DATA_OUT(dout), .DATA_OUT_VALID(valid),
        .K_TRUE(kt), .WR_READY(wr_ready));
    ctrl_model i_ctrl (.clk(CLK), .k_true(kt), .rd_sel_n(rs), .wr_sel_n(ws), .addr(addr),
        .data(din), .lane_n(ln));
    // clock and hang guard
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // bits stored by one beat
    function automatic logic [35:0] lm(input logic [3:0] l);
        lm = 36'h0_0000_0000;
        for (int i = 0; i < 4; i++)
            if (!l[i] && !(X18_MODE && i > 1))
                lm |= 36'h0_0000_01FF << (9 * i);
    endfunction
    // one command pair; read beats checked under mask m
    task automatic go(input logic r, input logic [7:0] ra, input logic w, input logic [7:0] wa,
        input logic [35:0] d0, input logic [3:0] l0, input logic [35:0] d1,
        input logic [3:0] l1, input logic [35:0] m);
        logic [35:0] e0, e1;
        e0 = mem[ra];
        e1 = mem[8'(ra + 8'h01)];
        if (w)
        begin
            mem[wa] = (mem[wa] & ~lm(l0)) | (d0 & lm(l0));
            mem[8'(wa + 8'h01)] = (mem[8'(wa + 8'h01)] & ~lm(l1)) | (d1 & lm(l1));
        end
        i_ctrl.issue(r, ra, w, wa, d0, l0, d1, l1, 1'b0);
        if (r)
        begin
            repeat (3) @(posedge CLK);
            #1;
            chk({35'h0, valid}, 36'h0);
            @(posedge CLK);
            #1;
            chk(dout & m, e0 & m);
            @(posedge CLK);
            #1;
            chk(dout & m, e1 & m);
        end
        repeat (4) @(posedge CLK);
        #1;
        for (int n = 0; n < 20 && wr_ready !== 1'b1; n++)
        begin
            @(posedge CLK);
            #1;
        end
        chk({35'h0, wr_ready}, 36'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [35:0] m);
        go(1'b1, a, 1'b0, 8'h00, 36'h0_0000_0000, 4'hF, 36'h0_0000_0000, 4'hF, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [35:0] d0, input logic [3:0] l0,
        input logic [35:0] d1, input logic [3:0] l1);
        go(1'b0, 8'h00, 1'b1, a, d0, l0, d1, l1, 36'h0_0000_0000);
    endtask
    task automatic t_lanes();
        wr(8'h10, 36'h1_2345_6789, 4'h0, 36'hF_EDCB_A987, 4'h0);
        rd(8'h10, 36'hF_FFFF_FFFF);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h10, {4{9'h0A0 + 9'(i)}}, ~(4'h1 << i), {4{9'h150 - 9'(i)}}, ~(4'h8 >> i));
            rd(8'h10, 36'hF_FFFF_FFFF);
        end
        wr(8'h10, 36'h0_0000_0000, 4'hF, 36'h0_0000_0000, 4'hE);
        rd(8'h10, 36'hF_FFFF_FFFF);
    endtask
    task automatic t_narrow();
        X18_MODE = 1'b1;
        wr(8'h30, 36'hF_FFFF_FFFF, 4'hC, 36'hF_FFFF_FFFF, 4'hC);
        wr(8'h30, 36'h0_0000_0000, 4'hD, 36'h0_0000_0000, 4'h3);
        rd(8'h30, 36'h0_0003_FFFF);
        X18_MODE = 1'b0;
    endtask
    task automatic t_concur();
        go(1'b1, 8'h10, 1'b1, 8'hFF, 36'hA_5A5A_5A5A, 4'h0, 36'h5_A5A5_A5A5, 4'h0,
            36'hF_FFFF_FFFF);
        rd(8'hFF, 36'hF_FFFF_FFFF);
    endtask
    task automatic t_odd();
        i_ctrl.issue(1'b1, 8'h10, 1'b0, 8'h00, 36'h0_0000_0000, 4'hF, 36'h0_0000_0000, 4'hF,
            1'b1);
        repeat (8)
        begin
            @(posedge CLK);
            #1;
            chk({35'h0, valid}, 36'h0);
        end
    endtask
    // reset, then the scenarios
    initial
    begin
        NRST = 1'b0;
        X18_MODE = 1'b0;
        repeat (5) @(posedge CLK);
        #1;
        NRST = 1'b1;
        t_lanes();
        t_narrow();
        t_concur();
        t_odd();
        conclude();
    end
endmodule
